// ---- hdl/cti_can_test_irq.sv ----
// CAN test-mode pin routing, interrupt source status/enable and search mask
//
// What this block does
// RULE_01: test enable one turns selected test on; zero gives normal operation.
// RULE_02: select field: 00 none, 01 listen-only, 10 external loop, 11 internal.
// RULE_03: software writes test control only in halt mode.
// RULE_04: listen-only still accepts and stores valid data and remote frames.
// RULE_05: listen-only drives only recessive; no ack, overload or error flag.
// RULE_06: software requests no transmission during listen-only.
// RULE_07: external loop stores own frames as received and makes its own ack.
// RULE_08: internal loop stores own frames as received and makes its own ack.
// RULE_09: internal loop feeds transmit to receive; external receive pin ignored.
// RULE_10: internal loop holds the external transmit pin recessive.
// RULE_11: interrupt status shows raw sources before enable masking.
// RULE_12: status bit 5 is any enabled error flag; writes ignored.
// RULE_13: bit 4 set on receive queue full/warn with enable 61; write 0 clears.
// RULE_14: bit 3 set on transmit queue count hit with enable 57; write 0 clears.
// RULE_15: bit 2 set when mailbox 0 finishes storing fresh data, enable 0.
// RULE_16: bit 1 same completion for mailboxes 1 to 63 with their enables.
// RULE_17: bit 0 set when mailbox 32..63 transmit done with its enable.
// RULE_18: bits 7 and 6 of status and enable read zero; software writes zero.
// RULE_19: enable register holds one enable per source, one enables it.
// RULE_20: each request output is high while status and enable are both one.
// RULE_21: software writes the search mask only in halt mode.
// RULE_22: mask bit 0 drops mailbox 0 from search except in channel search.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module cti_can_test_irq #(
    parameter int NUM_BOXES = 64
) (
    input  wire logic                   clk_in,
    input  wire logic                   arst_n_in,
    input  wire logic                   ce_in,
    input  wire logic [31:0]            avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    input  wire logic [3:0]             avs_byteenable_in,
    output logic      [31:0]            avs_readdata_out,
    output logic                        avs_waitrequest_out,
    input  wire logic                   controller_reset_mode_in,
    input  wire logic                   bus_receive_pin_in,
    output logic                        bus_transmit_pin_out,
    input  wire logic                   proto_tx_in,
    output logic                        proto_rx_out,
    output logic                        proto_self_ack_out,
    output logic                        proto_listen_only_out,
    output logic                        proto_store_own_out,
    input  wire logic [7:0]             error_flag_reg_in,
    input  wire logic [7:0]             error_enable_reg_in,
    input  wire logic [7:0]             receive_queue_control_in,
    input  wire logic                   txq_count_hit_in,
    input  wire logic [NUM_BOXES-1:0]   mailbox_irq_enables_in,
    input  wire logic [NUM_BOXES-1:0]   fresh_data_flag_in,
    input  wire logic [NUM_BOXES-1:0]   storing_in_progress_flag_in,
    input  wire logic [NUM_BOXES-1:0]   transmit_done_flag_in,
    input  wire logic                   search_channel_mode_in,
    input  wire logic [NUM_BOXES-1:0]   search_candidates_in,
    output logic      [NUM_BOXES-1:0]   search_candidates_out,
    output logic                        first_box_search_exclude_out,
    output logic [cti_pkg::NUM_SRC-1:0] irq_out
);
    import cti_pkg::*;

    // ---------------- bus slave ----------------
    cti_bus_t   bus_state;
    cti_bus_t   next_bus_state;
    logic [31:0] next_readdata;
    logic       bus_req;
    logic       bus_done;
    logic       wr_test;
    logic       wr_status;
    logic       wr_enable;
    logic       wr_mask;
    logic [7:0] wdata;

    // one wait cycle gives a registered read path
    assign bus_req  = avs_read_in | avs_write_in;
    assign bus_done = (bus_state == BUS_ACK) & ce_in;
    assign avs_waitrequest_out = bus_req & ~bus_done;

    assign wdata     = avs_writedata_in[7:0];
    assign wr_test   = bus_done & avs_write_in & avs_byteenable_in[0]
                     & (avs_address_in == TEST_CONTROL_ADDR);
    assign wr_status = bus_done & avs_write_in & avs_byteenable_in[0]
                     & (avs_address_in == IRQ_STATUS_ADDR);
    assign wr_enable = bus_done & avs_write_in & avs_byteenable_in[0]
                     & (avs_address_in == IRQ_ENABLE_ADDR);
    assign wr_mask   = bus_done & avs_write_in & avs_byteenable_in[0]
                     & (avs_address_in == SEARCH_MASK_ADDR);

    // ---------------- registers ----------------
    logic [7:0] test_control_reg;
    logic [7:0] next_test_control_reg;
    logic [7:0] irq_source_status;
    logic [7:0] next_irq_source_status;
    logic [7:0] irq_enable_reg;
    logic [7:0] next_irq_enable_reg;
    logic [7:0] search_mask_reg;
    logic [7:0] next_search_mask_reg;

    always_comb begin
        next_bus_state = bus_state;
        next_readdata  = avs_readdata_out;
        case (bus_state)
            BUS_IDLE: begin
                if (bus_req) begin
                    next_bus_state = BUS_ACK;
                    next_readdata  = 32'h0;
                    // unmapped addresses read zero and ignore writes
                    case (avs_address_in)
                        TEST_CONTROL_ADDR: next_readdata[7:0] = test_control_reg;
                        IRQ_STATUS_ADDR:   next_readdata[7:0] = irq_source_status; // RULE_11
                        IRQ_ENABLE_ADDR:   next_readdata[7:0] = irq_enable_reg;
                        SEARCH_MASK_ADDR:  next_readdata[7:0] = search_mask_reg;
                        default:           next_readdata = 32'h0;
                    endcase
                end
            end
            BUS_ACK:  next_bus_state = BUS_IDLE;
            default:  next_bus_state = BUS_IDLE;
        endcase
    end

    // ---------------- test mode routing ----------------
    cti_test_t  eff_mode;
    logic       rx_meta;
    logic       rx_sync;
    logic       next_tx_pin;
    logic       next_proto_rx;

    // disabled test mode forces the normal path
    assign eff_mode = test_control_reg[TEST_ENABLE_BIT]
                    ? cti_test_t'(test_control_reg[TEST_SEL_LSB +: 2])
                    : TEST_NONE; // RULE_01 RULE_02

    always_comb begin
        next_tx_pin   = proto_tx_in;
        next_proto_rx = rx_sync; // RULE_04
        case (eff_mode)
            TEST_NONE:   next_tx_pin = proto_tx_in;
            TEST_LISTEN: next_tx_pin = RECESSIVE; // RULE_05
            TEST_EXT:    next_tx_pin = proto_tx_in; // RULE_07
            TEST_INT: begin
                next_tx_pin   = RECESSIVE; // RULE_10
                next_proto_rx = proto_tx_in; // RULE_09
            end
            default:     next_tx_pin = proto_tx_in;
        endcase
    end

    // ---------------- interrupt sources ----------------
    logic [NUM_BOXES-1:0] storing_prev;
    logic                 rxq_prev;
    logic                 txq_prev;
    logic                 boxtx_prev;
    logic [NUM_BOXES-1:0] rx_done;
    logic                 rxq_cond;
    logic                 boxtx_cond;
    logic [NUM_SRC-1:0]   src_set;
    logic [NUM_SRC-1:0]   src_clr;

    // completed store: fresh data and storing flag just fell
    assign rx_done = fresh_data_flag_in & storing_prev & ~storing_in_progress_flag_in
                   & mailbox_irq_enables_in;
    assign rxq_cond = (receive_queue_control_in[RXQ_FULL_BIT]
                    | receive_queue_control_in[RXQ_WARN_BIT])
                    & mailbox_irq_enables_in[RXQ_MIER_BIT];
    assign boxtx_cond = |(transmit_done_flag_in[NUM_BOXES-1:TX_BOX_FIRST]
                        & mailbox_irq_enables_in[NUM_BOXES-1:TX_BOX_FIRST]);

    always_comb begin
        src_set              = '0;
        src_set[SRC_ERROR]   = |(error_flag_reg_in & error_enable_reg_in); // RULE_12
        src_set[SRC_RXQ]     = rxq_cond & ~rxq_prev; // RULE_13
        src_set[SRC_TXQ]     = txq_count_hit_in & ~txq_prev
                             & mailbox_irq_enables_in[TXQ_MIER_BIT]; // RULE_14
        src_set[SRC_BOX0_RX] = rx_done[0]; // RULE_15
        src_set[SRC_BOXN_RX] = |rx_done[NUM_BOXES-1:1]; // RULE_16
        src_set[SRC_BOX_TX]  = boxtx_cond & ~boxtx_prev; // RULE_17
        // writing zero clears, writing one leaves the bit alone
        src_clr = wr_status ? ~wdata[NUM_SRC-1:0] : '0;
        src_clr[SRC_ERROR] = 1'b0; // RULE_12
    end

    always_comb begin
        next_test_control_reg = test_control_reg;
        next_irq_enable_reg   = irq_enable_reg;
        next_search_mask_reg  = search_mask_reg;
        next_irq_source_status = 8'h00;
        // hardware set beats a same-cycle software clear
        next_irq_source_status[NUM_SRC-1:0] = (irq_source_status[NUM_SRC-1:0] & ~src_clr)
                                            | src_set; // RULE_13 RULE_14
        // error source follows its flags live
        next_irq_source_status[SRC_ERROR] = src_set[SRC_ERROR]; // RULE_12
        if (wr_test) begin
            next_test_control_reg = {5'h0, wdata[2:0]};
        end
        if (wr_enable) begin
            next_irq_enable_reg = {2'h0, wdata[NUM_SRC-1:0]}; // RULE_18 RULE_19
        end
        if (wr_mask) begin
            next_search_mask_reg = {7'h0, wdata[SEARCH_EXCLUDE_BIT]};
        end
        // controller reset mode reinitialises all but the enable register
        if (controller_reset_mode_in) begin
            next_test_control_reg  = TEST_CONTROL_RST;
            next_irq_source_status = IRQ_STATUS_RST;
            next_search_mask_reg   = SEARCH_MASK_RST;
        end
    end

    // ---------------- search mask ----------------
    logic                 next_exclude;
    logic [NUM_BOXES-1:0] next_candidates;

    always_comb begin
        next_exclude    = search_mask_reg[SEARCH_EXCLUDE_BIT] & ~search_channel_mode_in;
        next_candidates = search_candidates_in;
        if (next_exclude) begin
            next_candidates[0] = 1'b0; // RULE_22
        end
    end

    // ---------------- state registers ----------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_state                    <= BUS_IDLE;
            avs_readdata_out             <= 32'h0;
            test_control_reg             <= TEST_CONTROL_RST;
            irq_source_status            <= IRQ_STATUS_RST;
            irq_enable_reg               <= IRQ_ENABLE_RST;
            search_mask_reg              <= SEARCH_MASK_RST;
            rx_meta                      <= RECESSIVE;
            rx_sync                      <= RECESSIVE;
            bus_transmit_pin_out         <= RECESSIVE;
            proto_rx_out                 <= RECESSIVE;
            storing_prev                 <= '0;
            rxq_prev                     <= 1'b0;
            txq_prev                     <= 1'b0;
            boxtx_prev                   <= 1'b0;
            first_box_search_exclude_out <= 1'b0;
            search_candidates_out        <= '0;
        end else if (ce_in) begin
            bus_state                    <= next_bus_state;
            avs_readdata_out             <= next_readdata;
            test_control_reg             <= next_test_control_reg;
            irq_source_status            <= next_irq_source_status;
            irq_enable_reg               <= next_irq_enable_reg;
            search_mask_reg              <= next_search_mask_reg;
            rx_meta                      <= bus_receive_pin_in;
            rx_sync                      <= rx_meta;
            bus_transmit_pin_out         <= next_tx_pin;
            proto_rx_out                 <= next_proto_rx;
            storing_prev                 <= storing_in_progress_flag_in;
            rxq_prev                     <= rxq_cond;
            txq_prev                     <= txq_count_hit_in;
            boxtx_prev                   <= boxtx_cond;
            first_box_search_exclude_out <= next_exclude;
            search_candidates_out        <= next_candidates;
        end
    end

    // protocol qualifiers derive from registered mode, so they are glitch free
    assign proto_listen_only_out = (eff_mode == TEST_LISTEN); // RULE_05
    assign proto_self_ack_out    = (eff_mode == TEST_EXT) | (eff_mode == TEST_INT); // RULE_07 RULE_08
    assign proto_store_own_out   = proto_self_ack_out; // RULE_08
    assign irq_out = irq_source_status[NUM_SRC-1:0] & irq_enable_reg[NUM_SRC-1:0]; // RULE_20

    // ---------------- checks ----------------
    sequence s_int_loop;
        ce_in && (eff_mode == TEST_INT);
    endsequence

    sequence s_box0_done;
        ce_in && storing_in_progress_flag_in[0] ##1
        ce_in && !storing_in_progress_flag_in[0] && fresh_data_flag_in[0]
              && mailbox_irq_enables_in[0] && !controller_reset_mode_in;
    endsequence

    chk_int_tx_recessive: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_10
        s_int_loop |=> bus_transmit_pin_out == RECESSIVE)
        else $error("internal loop transmit pin not recessive");

    chk_int_loop_feed: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_09
        s_int_loop |=> proto_rx_out == $past(proto_tx_in))
        else $error("internal loop receive not fed from transmit");

    chk_listen_silent: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_05
        ce_in && eff_mode == TEST_LISTEN |=> bus_transmit_pin_out == RECESSIVE
                                          && proto_rx_out == $past(rx_sync))
        else $error("listen-only drove the bus or lost receive");

    chk_test_off_normal: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_01
        ce_in && !test_control_reg[TEST_ENABLE_BIT]
        |-> !proto_self_ack_out && !proto_listen_only_out
            ##1 bus_transmit_pin_out == $past(proto_tx_in))
        else $error("test behaviour active while disabled");

    chk_ext_self_ack: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_07
        eff_mode == TEST_EXT |-> proto_self_ack_out && proto_store_own_out
                                 && !proto_listen_only_out)
        else $error("external loop without own ack");

    chk_irq_gate: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_20
        irq_out[SRC_TXQ] == (irq_source_status[SRC_TXQ] && irq_enable_reg[SRC_TXQ]))
        else $error("request not gated by enable");

    chk_box0_set: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_15
        s_box0_done |=> irq_source_status[SRC_BOX0_RX])
        else $error("mailbox 0 reception not flagged");

    chk_rxq_set_wins: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_13
        ce_in && src_set[SRC_RXQ] && !controller_reset_mode_in
        |=> irq_source_status[SRC_RXQ] ##1 1'b1)
        else $error("receive queue event lost");

    chk_error_live: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_12
        ce_in && !controller_reset_mode_in
        |=> irq_source_status[SRC_ERROR]
            == |($past(error_flag_reg_in) & $past(error_enable_reg_in)))
        else $error("error status does not follow enabled flags");

    chk_high_bits_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_18
        irq_source_status[7:6] == 2'h0 && irq_enable_reg[7:6] == 2'h0)
        else $error("reserved status or enable bits set");

    chk_enable_write: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_19
        wr_enable |=> irq_enable_reg[NUM_SRC-1:0] == $past(wdata[NUM_SRC-1:0]))
        else $error("enable register write lost");

    chk_mask_exclude: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE_22
        ce_in && search_mask_reg[SEARCH_EXCLUDE_BIT] && !search_channel_mode_in
        |=> !search_candidates_out[0] && first_box_search_exclude_out)
        else $error("mailbox 0 not excluded from search");

    chk_bus_answer: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && bus_req && bus_state == BUS_IDLE ##1 ce_in |-> !avs_waitrequest_out)
        else $error("bus answer late");
endmodule : cti_can_test_irq

// ---- hdl/cti_pkg.sv ----
// constants for the CAN test-mode, interrupt-status and search-mask block
package cti_pkg;
    // register byte addresses on the slave bus
    localparam logic [31:0] TEST_CONTROL_ADDR = 32'hffff6858;
    localparam logic [31:0] IRQ_STATUS_ADDR   = 32'hffff685c;
    localparam logic [31:0] IRQ_ENABLE_ADDR   = 32'hffff6860;
    localparam logic [31:0] SEARCH_MASK_ADDR  = 32'hffff6864;

    // reset values
    localparam logic [7:0] TEST_CONTROL_RST = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RST   = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RST   = 8'h00;
    localparam logic [7:0] SEARCH_MASK_RST  = 8'h00;

    // test control fields
    localparam int TEST_ENABLE_BIT = 0;
    localparam int TEST_SEL_LSB    = 1;

    // interrupt source positions, shared by status and enable
    localparam int SRC_ERROR   = 5;
    localparam int SRC_RXQ     = 4;
    localparam int SRC_TXQ     = 3;
    localparam int SRC_BOX0_RX = 2;
    localparam int SRC_BOXN_RX = 1;
    localparam int SRC_BOX_TX  = 0;
    localparam int NUM_SRC     = 6;

    // mailbox interrupt enable positions and receive queue control bits
    localparam int RXQ_MIER_BIT  = 61;
    localparam int TXQ_MIER_BIT  = 57;
    localparam int TX_BOX_FIRST  = 32;
    localparam int RXQ_FULL_BIT  = 6;
    localparam int RXQ_WARN_BIT  = 5;

    localparam int SEARCH_EXCLUDE_BIT = 0;

    localparam logic RECESSIVE = 1'b1;

    typedef enum logic [1:0] {
        TEST_NONE   = 2'h0,
        TEST_LISTEN = 2'h1,
        TEST_EXT    = 2'h2,
        TEST_INT    = 2'h3
    } cti_test_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK  = 1'h1
    } cti_bus_t;
endpackage : cti_pkg

// ---- verification/cti_can_test_irq_bench.sv ----
// self-checking testbench for the CAN test-mode, interrupt-status and search-mask block
`timescale 1ns/1ps
module cti_can_test_irq_bench;
    import cti_pkg::*;
    logic        clk_in;
    logic        arst_n_in;
    logic        ce;
    logic [31:0] addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wait_req;
    logic        rst_mode;
    logic        rx_pin;
    logic        tx_pin;
    logic        ptx;
    logic        prx;
    logic        self_ack;
    logic        listen;
    logic        store_own;
    logic        remote_dom;
    logic [7:0]  err_flag;
    logic [7:0]  err_en;
    logic [7:0]  rxq_ctl;
    logic        txq_hit;
    logic [63:0] mier;
    logic [63:0] fresh;
    logic [63:0] storing;
    logic [63:0] tx_done;
    logic        chan_mode;
    logic [63:0] cand_in;
    logic [63:0] cand_out;
    logic        excl;
    logic [5:0]  irq;
    logic [31:0] d;
    logic [2:0]  tc_tab [5];
    logic        lo;
    logic        lp;
    logic        il;
    int          error_cnt;
    int          checks_done;

    cti_can_test_irq #(.NUM_BOXES(64)) dut_u (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
        .controller_reset_mode_in(rst_mode), .bus_receive_pin_in(rx_pin),
        .bus_transmit_pin_out(tx_pin), .proto_tx_in(ptx), .proto_rx_out(prx),
        .proto_self_ack_out(self_ack), .proto_listen_only_out(listen),
        .proto_store_own_out(store_own), .error_flag_reg_in(err_flag),
        .error_enable_reg_in(err_en), .receive_queue_control_in(rxq_ctl),
        .txq_count_hit_in(txq_hit), .mailbox_irq_enables_in(mier),
        .fresh_data_flag_in(fresh), .storing_in_progress_flag_in(storing),
        .transmit_done_flag_in(tx_done), .search_channel_mode_in(chan_mode),
        .search_candidates_in(cand_in), .search_candidates_out(cand_out),
        .first_box_search_exclude_out(excl), .irq_out(irq)
    );

    cti_xcvr_model xcvr_u (.txd_in(tx_pin), .remote_dominant_in(remote_dom), .rxd_out(rx_pin));

    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // held until waitrequest is seen low at a rising edge; only the watchdog ends a hang
    task automatic bus_op(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        addr <= a;
        rd <= ~w;
        wr <= w;
        wdata <= wd;
        do @(posedge clk_in); while (wait_req !== 1'b0);
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus_op

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus_op(1'b0, a, 32'h0);
        chk(d, exp);
    endtask : rdchk

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask : settle

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        {arst_n_in, rd, wr, rst_mode, ptx, remote_dom, txq_hit, chan_mode} = 8'h0;
        {addr, wdata, err_flag, err_en, rxq_ctl} = '0;
        {mier, fresh, storing, tx_done, cand_in} = '0;
        ce = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        // select/enable pairs; the first and the last have the enable off
        tc_tab = '{3'h0, 3'h3, 3'h5, 3'h7, 3'h6};
        repeat (12) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rdchk(TEST_CONTROL_ADDR, {24'h0, TEST_CONTROL_RST});
        rdchk(IRQ_STATUS_ADDR, {24'h0, IRQ_STATUS_RST});
        rdchk(IRQ_ENABLE_ADDR, {24'h0, IRQ_ENABLE_RST});
        rdchk(SEARCH_MASK_ADDR, {24'h0, SEARCH_MASK_RST});
        bus_op(1'b1, IRQ_ENABLE_ADDR, 32'h3f);
        rdchk(IRQ_ENABLE_ADDR, 32'h3f);
        rdchk(32'hffff6870, 32'h0);
        // the bench plays software: test control set as if halted, no mailbox transmit asked
        for (int i = 0; i < 5; i++) begin
            bus_op(1'b1, TEST_CONTROL_ADDR, {29'h0, tc_tab[i]});
            lo = (tc_tab[i] == 3'h3);
            lp = tc_tab[i][0] & tc_tab[i][2];
            il = (tc_tab[i] == 3'h7);
            @(posedge clk_in);
            ptx <= 1'b0;
            remote_dom <= 1'b0;
            settle(6);
            chk(listen, lo);
            chk(self_ack, lp);
            chk(store_own, lp);
            chk(tx_pin, lo | il);
            chk(prx, lo);
            @(posedge clk_in);
            ptx <= 1'b1;
            remote_dom <= 1'b1;
            settle(6);
            chk(prx, il);
        end
        @(posedge clk_in);
        remote_dom <= 1'b0;
        err_flag <= 8'h04;
        err_en <= 8'h04;
        settle(2);
        chk(irq, 6'h20);
        rdchk(IRQ_STATUS_ADDR, 32'h20);
        bus_op(1'b1, IRQ_STATUS_ADDR, 32'h0);
        rdchk(IRQ_STATUS_ADDR, 32'h20);
        // clock enable low must freeze the status bit despite the changed enables
        @(posedge clk_in);
        ce <= 1'b0;
        err_en <= 8'h02;
        settle(2);
        chk(irq, 6'h20);
        @(posedge clk_in);
        ce <= 1'b1;
        settle(2);
        rdchk(IRQ_STATUS_ADDR, 32'h0);
        mier[RXQ_MIER_BIT] <= 1'b1;
        mier[TXQ_MIER_BIT] <= 1'b1;
        for (int i = 5; i < 7; i++) begin
            @(posedge clk_in);
            rxq_ctl <= 8'h1 << i;
            settle(2);
            rdchk(IRQ_STATUS_ADDR, 32'h10);
            bus_op(1'b1, IRQ_STATUS_ADDR, 32'h10);
            rdchk(IRQ_STATUS_ADDR, 32'h10);
            bus_op(1'b1, IRQ_STATUS_ADDR, 32'h0);
            rdchk(IRQ_STATUS_ADDR, 32'h0);
            @(posedge clk_in);
            rxq_ctl <= 8'h0;
        end
        @(posedge clk_in);
        txq_hit <= 1'b1;
        settle(2);
        chk(irq, 6'h08);
        bus_op(1'b1, IRQ_ENABLE_ADDR, 32'h37);
        settle(1);
        chk(irq, 6'h00);
        rdchk(IRQ_STATUS_ADDR, 32'h08);
        bus_op(1'b1, IRQ_STATUS_ADDR, 32'h0);
        rdchk(IRQ_STATUS_ADDR, 32'h0);
        bus_op(1'b1, IRQ_ENABLE_ADDR, 32'h3f);
        // mailbox 0 feeds bit 2, the highest mailbox bit 1
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_in);
            mier[b * 63] <= 1'b1;
            fresh[b * 63] <= 1'b1;
            storing[b * 63] <= 1'b1;
            @(posedge clk_in);
            storing[b * 63] <= 1'b0;
            settle(2);
            rdchk(IRQ_STATUS_ADDR, b ? 32'h02 : 32'h04);
            bus_op(1'b1, IRQ_STATUS_ADDR, 32'h0);
        end
        @(posedge clk_in);
        mier[31] <= 1'b1;
        tx_done[31] <= 1'b1;
        settle(2);
        rdchk(IRQ_STATUS_ADDR, 32'h0);
        @(posedge clk_in);
        mier[TX_BOX_FIRST] <= 1'b1;
        tx_done[TX_BOX_FIRST] <= 1'b1;
        settle(2);
        chk(irq, 6'h01);
        rdchk(IRQ_STATUS_ADDR, 32'h01);
        @(posedge clk_in);
        cand_in <= '1;
        bus_op(1'b1, SEARCH_MASK_ADDR, 32'h1);
        settle(2);
        chk(excl, 1'b1);
        chk(cand_out, 64'hffff_ffff_ffff_fffe);
        @(posedge clk_in);
        chan_mode <= 1'b1;
        settle(2);
        chk(excl, 1'b0);
        chk(cand_out, 64'hffff_ffff_ffff_ffff);
        @(posedge clk_in);
        rst_mode <= 1'b1;
        settle(2);
        rdchk(SEARCH_MASK_ADDR, 32'h0);
        end_of_test();
    end
endmodule : cti_can_test_irq_bench

// ---- verification/cti_xcvr_model.sv ----
// transceiver model on the CAN pins, with a second node able to pull the bus dominant
`timescale 1ns/1ps
module cti_xcvr_model (
    input  wire logic txd_in,
    input  wire logic remote_dominant_in,
    output logic      rxd_out
);
    // wired-and bus: recessive (1) unless some node drives dominant
    assign rxd_out = txd_in & ~remote_dominant_in;
endmodule : cti_xcvr_model
